// ===== rtl/task_switch_params.svh
`ifndef TASK_SWITCH_PARAMS_SVH
`define TASK_SWITCH_PARAMS_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_NEW_TSS_SEL 8'h04
`define OFS_TSS_DESC 8'h08
`define OFS_TSS_LIMIT 8'h0C
`define OFS_GDT_LIMIT 8'h10
`define OFS_CUR_IP 8'h14
`define OFS_TR_SEL 8'h18
`define OFS_CR0 8'h1C
`define OFS_STATUS 8'h20
`define OFS_ERR_CODE 8'h24
`define OFS_SAVED_IP 8'h28
`define OFS_NEW_IP 8'h2C
`define OFS_SEG_BASE 8'h40
`define NUM_SEGS 7

// Segment slots, in check order
`define SEG_LDT 3'h0
`define SEG_CS 3'h1
`define SEG_SS 3'h2

// Field positions
`define CTRL_START 0
`define TSS_PRESENT 0
`define TSS_BUSY 1
`define TSS_IS32 2
`define CR0_TS 3
`define ATTR_OK 16
`define ATTR_TYPE 17
`define ATTR_PRES 18
`define ATTR_DPL 19
`define ATTR_READ 21
`define ATTR_CONF 22

// Least state segment limits
`define TSS32_MIN_LIMIT 32'h0000006C
`define TSS16_MIN_LIMIT 32'h0000002C

// Documented step numbers shown in status
`define STEP_SEL 4'h1
`define STEP_PRES 4'h3
`define STEP_BUSY 4'h4
`define STEP_SAVE 4'h8
`define STEP_TR 4'hB
`define STEP_LOAD 4'hC
`define STEP_SEGS 4'hD
`define STEP_START 4'hE

`endif

// ===== rtl/task_switch_pkg.sv
package task_switch_pkg;

    typedef enum logic [3:0] {
        ST_IDLE, ST_TSS_SEL, ST_TSS_PRES, ST_TSS_BUSY, ST_TSS_LIM,
        ST_SAVE, ST_TR_LOAD, ST_STATE_LOAD, ST_SEG_CHK, ST_START
    } seq_state_t;

    typedef enum logic [1:0] {
        CAUSE_JUMP, CAUSE_CALL, CAUSE_INT, CAUSE_INTERRUPT_RETURN
    } cause_t;

    typedef enum logic [2:0] {
        F_NONE, F_GENERAL_PROT, F_INVALID_STATE_SEG, F_NOT_PRESENT, F_STACK
    } fault_t;

    // Complete state of the switch unit
    typedef struct packed {
        seq_state_t state;
        cause_t cause;
        logic busy;
        logic done;
        logic fault;
        logic committed;
        logic new_env;
        fault_t fkind;
        logic [15:0] err;
        logic [2:0] seg_idx;
        logic cr0_ts;
        logic [1:0] current_privilege_level;
        logic [1:0] old_cpl;
        logic [15:0] tr_sel;
        logic [15:0] old_tr;
        logic [15:0] new_sel;
        logic [2:0] tss_desc;
        logic [31:0] tss_lim;
        logic [15:0] gdt_lim;
        logic [31:0] cur_ip;
        logic [31:0] saved_ip;
        logic [31:0] pend_ip;
        logic [31:0] new_ip;
        logic [6:0][22:0] seg;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } unit_state_t;

endpackage : task_switch_pkg

// ===== rtl/task_switch_check_commit.sv
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "task_switch_params.svh"

module task_switch_check_commit (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Memory side error while walking the tables
    input wire logic mem_err,
    // Task-switched flag
    output logic task_switched_flag
);

    task_switch_pkg::unit_state_t q;
    task_switch_pkg::unit_state_t d;

    // Fault a segment slot would raise; order valid, privilege, present
    function automatic task_switch_pkg::fault_t seg_fault(
        input logic [2:0] idx,
        input logic [22:0] w,
        input logic [1:0] current_privilege_level);
        logic valid;
        logic [1:0] descriptor_privilege_level;
        logic [1:0] requested_privilege_level;
        valid = w[`ATTR_OK] & w[`ATTR_TYPE];
        descriptor_privilege_level = w[`ATTR_DPL+1:`ATTR_DPL];
        requested_privilege_level = w[1:0];
        seg_fault = task_switch_pkg::F_NONE;
        if (idx == `SEG_LDT) begin
            if (!valid || !w[`ATTR_PRES]) begin
                seg_fault = task_switch_pkg::F_INVALID_STATE_SEG;
            end
        end else if (idx == `SEG_CS) begin
            if (!valid || descriptor_privilege_level != requested_privilege_level) begin
                seg_fault = task_switch_pkg::F_INVALID_STATE_SEG;
            end else if (!w[`ATTR_PRES]) begin
                seg_fault = task_switch_pkg::F_NOT_PRESENT;
            end
        end else if (idx == `SEG_SS) begin
            if (!valid || descriptor_privilege_level != current_privilege_level || descriptor_privilege_level != requested_privilege_level) begin
                seg_fault = task_switch_pkg::F_INVALID_STATE_SEG;
            end else if (!w[`ATTR_PRES]) begin
                seg_fault = task_switch_pkg::F_STACK;
            end
        end else begin
            if (!valid || !w[`ATTR_READ] || (!w[`ATTR_CONF] && descriptor_privilege_level < current_privilege_level)) begin
                seg_fault = task_switch_pkg::F_INVALID_STATE_SEG;
            end else if (!w[`ATTR_PRES]) begin
                seg_fault = task_switch_pkg::F_NOT_PRESENT;
            end
        end
    endfunction : seg_fault

    // Error code from a selector: index and table bit, low flags zero
    function automatic logic [15:0] err_of(input logic [15:0] sel);
        err_of = {sel[15:2], 2'b00};
    endfunction : err_of

    // Documented step number of each sequencer state
    function automatic logic [3:0] step_of(input task_switch_pkg::seq_state_t s);
        unique case (s)
            task_switch_pkg::ST_IDLE: step_of = 4'h0;
            task_switch_pkg::ST_TSS_SEL: step_of = `STEP_SEL;
            task_switch_pkg::ST_TSS_PRES: step_of = `STEP_PRES;
            task_switch_pkg::ST_TSS_BUSY: step_of = `STEP_BUSY;
            task_switch_pkg::ST_TSS_LIM: step_of = `STEP_PRES;
            task_switch_pkg::ST_SAVE: step_of = `STEP_SAVE;
            task_switch_pkg::ST_TR_LOAD: step_of = `STEP_TR;
            task_switch_pkg::ST_STATE_LOAD: step_of = `STEP_LOAD;
            task_switch_pkg::ST_SEG_CHK: step_of = `STEP_SEGS;
            task_switch_pkg::ST_START: step_of = `STEP_START;
        endcase
    endfunction : step_of

    logic setup;
    logic wr;
    logic seg_hit;
    logic [2:0] seg_i;
    logic [15:0] tss_end;
    logic [31:0] tss_min;
    task_switch_pkg::fault_t sf;

    // Bus decode helpers
    assign setup = psel & ~penable;
    assign wr = psel & penable & q.pready & pwrite;
    assign seg_i = paddr[4:2];
    assign seg_hit = (paddr[7:5] == 3'(`OFS_SEG_BASE >> 5)) && (paddr[1:0] == 2'b00)
        && (seg_i < 3'(`NUM_SEGS));
    // Last byte of the selected table entry
    assign tss_end = {q.new_sel[15:3], 3'h7};
    assign tss_min = q.tss_desc[`TSS_IS32] ? `TSS32_MIN_LIMIT : `TSS16_MIN_LIMIT;
    assign sf = seg_fault(q.seg_idx, q.seg[q.seg_idx], q.current_privilege_level);

    // Next state: bus slave and switch sequencer
    always_comb begin
        d = q;
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        // Answer during setup so the access phase completes at once
        if (setup) begin
            d.pready = 1'b1;
            d.prdata = 32'h0000_0000;
            if (seg_hit) begin
                d.prdata = {9'h000, q.seg[seg_i]};
            end else begin
                unique case (paddr)
                    `OFS_CTRL: d.prdata = {29'h0, q.cause, q.busy};
                    `OFS_NEW_TSS_SEL: d.prdata = {16'h0, q.new_sel};
                    `OFS_TSS_DESC: d.prdata = {29'h0, q.tss_desc};
                    `OFS_TSS_LIMIT: d.prdata = q.tss_lim;
                    `OFS_GDT_LIMIT: d.prdata = {16'h0, q.gdt_lim};
                    `OFS_CUR_IP: d.prdata = q.cur_ip;
                    `OFS_TR_SEL: d.prdata = {16'h0, q.tr_sel};
                    `OFS_CR0: d.prdata = {28'h0, q.cr0_ts, 3'h0};
                    `OFS_STATUS: d.prdata = {18'h0, q.current_privilege_level, step_of(q.state),
                        q.fkind, q.new_env, q.committed, q.fault, q.done, q.busy};
                    `OFS_ERR_CODE: d.prdata = {16'h0, q.err};
                    `OFS_SAVED_IP: d.prdata = q.saved_ip;
                    `OFS_NEW_IP: d.prdata = q.new_ip;
                    default: d.pslverr = 1'b1;
                endcase
            end
        end
        // Writes; set-up registers are frozen while a switch runs
        if (wr && !q.pslverr) begin
            if (seg_hit && !q.busy) begin
                d.seg[seg_i] = pwdata[22:0];
            end else if (!q.busy) begin
                unique case (paddr)
                    `OFS_CTRL: begin
                        d.cause = task_switch_pkg::cause_t'(pwdata[2:1]);
                        if (pwdata[`CTRL_START]) begin
                            d.busy = 1'b1;
                            d.done = 1'b0;
                            d.fault = 1'b0;
                            d.committed = 1'b0;
                            d.new_env = 1'b0;
                            d.fkind = task_switch_pkg::F_NONE;
                            d.err = 16'h0000;
                            d.old_tr = q.tr_sel;
                            d.old_cpl = q.current_privilege_level;
                            d.state = task_switch_pkg::ST_TSS_SEL;
                        end
                    end
                    `OFS_NEW_TSS_SEL: d.new_sel = pwdata[15:0];
                    `OFS_TSS_DESC: d.tss_desc = pwdata[2:0];
                    `OFS_TSS_LIMIT: d.tss_lim = pwdata;
                    `OFS_GDT_LIMIT: d.gdt_lim = pwdata[15:0];
                    `OFS_CUR_IP: d.cur_ip = pwdata;
                    `OFS_TR_SEL: d.tr_sel = pwdata[15:0];
                    `OFS_NEW_IP: d.new_ip = pwdata;
                    default: ;
                endcase
            end
            // Clearing the flag is allowed at any time
            if (paddr == `OFS_CR0) begin
                d.cr0_ts = pwdata[`CR0_TS];
            end
        end

        // Sequencer; the sequencer state and commit flag pick the error path
        unique case (q.state)
            task_switch_pkg::ST_IDLE: ;
            task_switch_pkg::ST_TSS_SEL: begin
                // Global table only, entry inside its limit
                if (mem_err || q.new_sel[2] || tss_end > q.gdt_lim) begin
                    d.fkind = (q.cause == task_switch_pkg::CAUSE_INTERRUPT_RETURN)
                        ? task_switch_pkg::F_INVALID_STATE_SEG
                        : task_switch_pkg::F_GENERAL_PROT;
                    d.err = err_of(q.new_sel);
                    d.state = task_switch_pkg::ST_IDLE;
                end else begin
                    d.state = task_switch_pkg::ST_TSS_PRES;
                end
            end
            task_switch_pkg::ST_TSS_PRES: begin
                if (mem_err || !q.tss_desc[`TSS_PRESENT]) begin
                    d.fkind = task_switch_pkg::F_NOT_PRESENT;
                    d.err = err_of(q.new_sel);
                    d.state = task_switch_pkg::ST_IDLE;
                end else begin
                    d.state = task_switch_pkg::ST_TSS_BUSY;
                end
            end
            task_switch_pkg::ST_TSS_BUSY: begin
                d.state = task_switch_pkg::ST_TSS_LIM;
                if (q.cause == task_switch_pkg::CAUSE_INTERRUPT_RETURN) begin
                    if (mem_err || !q.tss_desc[`TSS_BUSY]) begin
                        d.fkind = task_switch_pkg::F_INVALID_STATE_SEG;
                        d.err = err_of(q.new_sel);
                        d.state = task_switch_pkg::ST_IDLE;
                    end
                end else if (mem_err || q.tss_desc[`TSS_BUSY]) begin
                    d.fkind = task_switch_pkg::F_GENERAL_PROT;
                    d.err = err_of(q.tr_sel);
                    d.state = task_switch_pkg::ST_IDLE;
                end
            end
            task_switch_pkg::ST_TSS_LIM: begin
                if (mem_err || q.tss_lim < tss_min) begin
                    d.fkind = task_switch_pkg::F_INVALID_STATE_SEG;
                    d.err = err_of(q.new_sel);
                    d.state = task_switch_pkg::ST_IDLE;
                end else begin
                    d.state = task_switch_pkg::ST_SAVE;
                end
            end
            task_switch_pkg::ST_SAVE: begin
                // Staged only; published with the task register
                d.pend_ip = q.cur_ip;
                d.state = mem_err ? task_switch_pkg::ST_IDLE
                    : task_switch_pkg::ST_TR_LOAD;
                if (mem_err) begin
                    d.fkind = task_switch_pkg::F_INVALID_STATE_SEG;
                    d.err = err_of(q.tr_sel);
                end
            end
            task_switch_pkg::ST_TR_LOAD: begin
                if (mem_err) begin
                    // Nothing published yet, so the old state stands
                    d.fkind = task_switch_pkg::F_INVALID_STATE_SEG;
                    d.err = err_of(q.new_sel);
                    d.state = task_switch_pkg::ST_IDLE;
                end else begin
                    d.tr_sel = q.new_sel;
                    d.saved_ip = q.pend_ip;
                    d.state = task_switch_pkg::ST_STATE_LOAD;
                end
            end
            task_switch_pkg::ST_STATE_LOAD: begin
                if (mem_err) begin
                    // Hand back to the old task's environment
                    d.tr_sel = q.old_tr;
                    d.current_privilege_level = q.old_cpl;
                    d.fkind = task_switch_pkg::F_INVALID_STATE_SEG;
                    d.err = err_of(q.new_sel);
                    d.state = task_switch_pkg::ST_IDLE;
                end else begin
                    // Privilege from the new code selector only
                    d.current_privilege_level = q.seg[`SEG_CS][1:0];
                    d.cur_ip = q.new_ip;
                    d.committed = 1'b1;
                    d.seg_idx = `SEG_LDT;
                    d.state = task_switch_pkg::ST_SEG_CHK;
                end
            end
            task_switch_pkg::ST_SEG_CHK: begin
                // First failure ends checking; switch still completes
                if (mem_err || sf != task_switch_pkg::F_NONE) begin
                    d.fkind = mem_err ? task_switch_pkg::F_INVALID_STATE_SEG : sf;
                    d.err = (q.seg_idx == `SEG_LDT)
                        ? err_of(q.seg[q.seg_idx][15:0]) : err_of(q.seg[q.seg_idx][15:0]);
                    d.fault = 1'b1;
                    d.new_env = 1'b1;
                    d.state = task_switch_pkg::ST_START;
                end else if (q.seg_idx == 3'(`NUM_SEGS - 1)) begin
                    d.state = task_switch_pkg::ST_START;
                end else begin
                    d.seg_idx = q.seg_idx + 3'h1;
                end
            end
            task_switch_pkg::ST_START: begin
                // Instruction pointer left at entry: first one not run
                d.cur_ip = q.new_ip;
                d.cr0_ts = 1'b1;
                d.busy = 1'b0;
                d.done = 1'b1;
                d.state = task_switch_pkg::ST_IDLE;
            end
        endcase
        // Any pre-commit exit with a fault code ends the switch unfinished
        if (q.busy && !q.committed && d.state == task_switch_pkg::ST_IDLE
            && q.state != task_switch_pkg::ST_IDLE) begin
            d.busy = 1'b0;
            d.fault = 1'b1;
            d.done = 1'b1;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else if (clk_en) begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign task_switched_flag = q.cr0_ts;

endmodule : task_switch_check_commit

`default_nettype wire

// ===== tb/switch_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "task_switch_params.svh"

module switch_chk (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Table walk and flag
    input wire logic mem_err,
    input wire logic task_switched_flag
);
    logic mapped;
    logic rd_stat;
    // Word map decode; most switch checks look at a status read
    assign mapped = paddr <= `OFS_NEW_IP || (paddr >= `OFS_SEG_BASE && paddr <= 8'h58);
    assign rd_stat = pready && !pwrite && paddr == `OFS_STATUS;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_answer_after_setup: assert property (clk_en && psel && !penable |-> ##1 pready)
        else $error("setup phase not answered in the next cycle");
    chk_ready_one_cycle: assert property (pready && clk_en |=> !pready)
        else $error("ready held longer than one cycle");
    chk_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    chk_err_on_unmapped: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == !mapped)
        else $error("slave error does not match the address map");
    chk_flag_after_switch: assert property (
        rd_stat && prdata[1] && !prdata[2] |-> task_switched_flag)
        else $error("finished switch left the task-switched flag clear");
    chk_flag_sw_clear: assert property (
        $fell(task_switched_flag) |-> $past(pwrite && penable && paddr == `OFS_CR0))
        else $error("task-switched flag cleared without a software write");
    chk_env_after_commit: assert property (
        rd_stat && prdata[4] |-> prdata[3] && prdata[2] && task_switched_flag)
        else $error("new-task fault delivery without a finished switch");
    chk_rollback_env: assert property (rd_stat && prdata[2] && !prdata[3] |-> !prdata[4])
        else $error("early fault delivered in the new task");
    chk_err_code_index: assert property (
        pready && !pwrite && paddr == `OFS_ERR_CODE |-> prdata[1:0] == 2'h0 && prdata[31:16] == 16'h0)
        else $error("error code is not a bare descriptor index");
    chk_fault_kind: assert property (rd_stat |-> prdata[2] == (prdata[7:5] != 3'h0))
        else $error("fault flag and fault kind disagree");
endmodule : switch_chk

bind task_switch_check_commit switch_chk i_switch_chk (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_err(mem_err), .task_switched_flag(task_switched_flag)
);
`default_nettype wire

// ===== tb/mem_side.sv
`timescale 1ns/1ps
`default_nettype none

module mem_side (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Accepted start write, and the step that should fail
    input wire logic go,
    input wire logic [3:0] err_step,
    // Table walk error
    output logic mem_err
);
    logic [3:0] cnt_q;
    // Count step cycles from the start; parks at 15 so a stale count fires only when the chosen step is 15
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
        end else if (go) begin
            cnt_q <= 4'h1;
        end else if (cnt_q != 4'h0 && cnt_q != 4'hF) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    // Zero step means the tables always answer cleanly
    assign mem_err = err_step != 4'h0 && cnt_q == err_step;
endmodule : mem_side
`default_nettype wire

// ===== tb/task_switch_check_commit_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "task_switch_params.svh"

module task_switch_check_commit_bench;
    logic pclk;
    logic presetn;
    logic clk_en;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic mem_err;
    logic task_switched_flag;
    logic go;
    logic [3:0] err_step;
    int fail_count;
    int num_checks;

    task_switch_check_commit i_task_switch_check_commit (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_err(mem_err), .task_switched_flag(task_switched_flag)
    );
    // Table side fails a chosen step counted from the accepted start write
    mem_side i_mem_side (
        .pclk(pclk), .presetn(presetn), .go(go), .err_step(err_step), .mem_err(mem_err)
    );
    assign go = psel && penable && pready && pwrite && paddr == `OFS_CTRL && pwdata[0];

    // Core clock, 8 ns
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task end_sim();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One transfer; request held until ready is seen high, released after that edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            fail_count++;
            end_sim();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask : rd

    // Good segment slot: valid, typed, present, privilege 3, readable
    function automatic logic [31:0] seg_word(input int i);
        return 32'h003F0043 + 32'(8 * i);
    endfunction : seg_word

    // Old task at selector 10, new one at 28; code selector asks for level 3
    task prep(input logic busy, input logic is32, input logic [31:0] lim);
        wr(`OFS_CR0, 32'h0);
        wr(`OFS_TR_SEL, 32'h00000010);
        wr(`OFS_GDT_LIMIT, 32'h000000FF);
        wr(`OFS_NEW_TSS_SEL, 32'h00000028);
        wr(`OFS_TSS_DESC, 32'({is32, busy, 1'b1}));
        wr(`OFS_TSS_LIMIT, lim);
        wr(`OFS_CUR_IP, 32'h00001234);
        wr(`OFS_NEW_IP, 32'h00005678);
        for (int i = 0; i < `NUM_SEGS; i++) begin
            wr(`OFS_SEG_BASE + 8'(4 * i), seg_word(i));
        end
    endtask : prep

    // Start a switch and poll until done, bounded
    task run(input logic [1:0] cause);
        logic [31:0] q;
        int n;
        wr(`OFS_CTRL, {29'h0, cause, 1'b1});
        n = 0;
        do begin
            rd(`OFS_STATUS, q);
            n++;
        end while (q[1] !== 1'b1 && n < 30);
        if (n >= 30) begin
            fail_count++;
            end_sim();
        end
    endtask : run

    task s_reset();
        logic [31:0] q;
        logic e;
        rd(`OFS_STATUS, q);
        chk("reset status", 32'h0, q);
        rd(`OFS_TR_SEL, q);
        chk("reset task register", 32'h0, q);
        rd(`OFS_CR0, q);
        chk("reset control zero", 32'h0, q);
        apb(1'b0, 8'h30, 32'h0, q, e);
        chk("unmapped error", 32'h1, 32'(e));
        chk("unmapped data", 32'h0, q);
    endtask : s_reset

    // Every cause succeeds; jump uses the smallest 16-bit limit
    task s_success();
        logic [31:0] q;
        for (int c = 0; c < 4; c++) begin
            prep(c == 3, c != 0, c == 0 ? 32'h0000002C : 32'h0000006C);
            run(2'(c));
            rd(`OFS_STATUS, q);
            chk("switch status", 32'h000000C2, 32'({q[13:12], q[7:5], q[2:0]}));
            rd(`OFS_SAVED_IP, q);
            chk("saved ip", 32'h00001234, q);
            rd(`OFS_TR_SEL, q);
            chk("task register", 32'h00000028, q);
            rd(`OFS_CUR_IP, q);
            chk("new ip", 32'h00005678, q);
            rd(`OFS_CR0, q);
            chk("control zero", 32'h00000008, q);
            chk("flag pin", 32'h1, 32'(task_switched_flag));
        end
    endtask : s_success

    // Faults before commit: selector, presence, busy both ways, both limits
    task s_early();
        logic [31:0] q;
        logic [2:0] fk;
        for (int k = 0; k < 7; k++) begin
            prep(k == 1 || k == 3, k != 6, k == 6 ? 32'h0000002B : k == 5 ? 32'h0000006B : 32'h0000006C);
            if (k < 2) wr(`OFS_GDT_LIMIT, 32'h00000020);
            if (k == 2) wr(`OFS_TSS_DESC, 32'h00000004);
            run(k == 1 || k == 4 ? 2'h3 : k == 3 ? 2'h1 : 2'h0);
            fk = k == 2 ? 3'h3 : (k == 0 || k == 3) ? 3'h1 : 3'h2;
            rd(`OFS_STATUS, q);
            chk("early status", 32'({2'b01, fk}), 32'({q[3:2], q[7:5]}));
            rd(`OFS_ERR_CODE, q);
            chk("early error code", k == 3 ? 32'h00000010 : 32'h00000028, q);
            rd(`OFS_TR_SEL, q);
            chk("early task register", 32'h00000010, q);
            rd(`OFS_CUR_IP, q);
            chk("early ip", 32'h00001234, q);
            rd(`OFS_CR0, q);
            chk("early control zero", 32'h0, q);
        end
    endtask : s_early

    // Segment faults after commit; the last case is a legal conforming data segment
    task automatic s_late();
        int slot [10] = '{0, 0, 1, 1, 2, 2, 3, 4, 5, 6};
        logic [31:0] clr [10] = '{32'h00010000, 32'h00040000, 32'h00080000, 32'h00040000,
            32'h00020000, 32'h00040000, 32'h00200000, 32'h00040000, 32'h00180000, 32'h00180000};
        logic [2:0] fk [10] = '{3'h2, 3'h2, 3'h2, 3'h3, 3'h2, 3'h4, 3'h2, 3'h3, 3'h2, 3'h0};
        logic [31:0] q;
        logic [4:0] e;
        for (int k = 0; k < 10; k++) begin
            prep(1'b0, 1'b1, 32'h0000006C);
            q = seg_word(slot[k]) & ~clr[k] | (k == 9 ? 32'h00400000 : 32'h0);
            wr(`OFS_SEG_BASE + 8'(4 * slot[k]), q);
            run(2'h0);
            e = {fk[k], fk[k] != 3'h0, fk[k] != 3'h0};
            rd(`OFS_STATUS, q);
            chk("late status", 32'(e), 32'({q[7:5], q[4], q[2]}));
            rd(`OFS_ERR_CODE, q);
            chk("late error code", k == 9 ? 32'h0 : 32'h00000040 + 32'(8 * slot[k]), q);
            rd(`OFS_TR_SEL, q);
            chk("late task register", 32'h00000028, q);
            rd(`OFS_CUR_IP, q);
            chk("late ip", 32'h00005678, q);
            chk("late flag", 32'h1, 32'(task_switched_flag));
        end
    endtask : s_late

    // Table error in the first step, then while loading the new state
    task s_mem();
        logic [31:0] q;
        for (int k = 0; k < 2; k++) begin
            prep(1'b0, 1'b1, 32'h0000006C);
            err_step <= k == 0 ? 4'h1 : 4'h7;
            run(2'h1);
            err_step <= 4'h0;
            rd(`OFS_STATUS, q);
            // Selector step reports a protection fault for a call, load step an invalid segment
            chk("table error status", k == 0 ? 32'h5 : 32'h9, 32'({q[7:5], q[4], q[2]}));
            rd(`OFS_TR_SEL, q);
            chk("table error task register", 32'h00000010, q);
            rd(`OFS_CR0, q);
            chk("table error control zero", 32'h0, q);
        end
    endtask : s_mem

    // Main sequence
    initial begin
        fail_count = 0;
        num_checks = 0;
        presetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        err_step = 4'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        s_reset();
        s_success();
        s_early();
        s_late();
        s_mem();
        end_sim();
    end
endmodule : task_switch_check_commit_bench
`default_nettype wire
